// ### verilog/pmd_pkg.sv
// constants for the program memory map and mode decode block
`default_nettype none
package pmd_pkg;
  localparam int          PC_W            = 21;
  localparam int          FLASH_AW        = 17;
  localparam int          EXT_AW          = 20;
  // on-chip flash size of this variant and derived boundaries
  localparam logic [20:0] FLASH_BYTES     = 21'h020000;
  localparam logic [20:0] CFG_BASE        = 21'h01FFF8;
  localparam logic [20:0] RESET_VEC       = 21'h000000;
  localparam logic [20:0] VEC_HI          = 21'h000008;
  localparam logic [20:0] VEC_LO          = 21'h000018;
  localparam logic [20:0] PC_STEP         = 21'h000002;
  localparam logic [20:0] CFG_WORD_STEP   = 21'h000002;
  // 80-pin package has the external bus; clear for the 64-pin package
  localparam logic        HAS_EXT_BUS     = 1'b1;
  // configuration area: words one to three loaded, word four reserved
  localparam logic [1:0]  CFG_LAST_WORD   = 2'h2;
  localparam logic [2:0]  CFG3L_IDX       = 3'h4;
  localparam int          CFG3L_LSB       = 32;
  localparam int          WAIT_BIT        = 7;
  localparam int          BW_BIT          = 6;
  localparam int          MODE_HI         = 5;
  localparam int          MODE_LO         = 4;
  localparam int          SHIFT_BIT       = 3;
  localparam logic [7:0]  CFG_ERASED      = 8'hFF;
  localparam logic [7:0]  CFG3L_MASK      = 8'hF8;
  localparam logic [63:0] CFG_RESET       = 64'hFFFF_FFF8_FFFF_FFFF;
  // memory mode codes
  localparam logic [1:0]  MODE_INT        = 2'h3;
  localparam logic [1:0]  MODE_A12        = 2'h2;
  localparam logic [1:0]  MODE_A16        = 2'h1;
  localparam logic [1:0]  MODE_A20        = 2'h0;
  localparam logic [20:0] MASK_A12        = 21'h000FFF;
  localparam logic [20:0] MASK_A16        = 21'h00FFFF;
  localparam logic [20:0] MASK_A20        = 21'h0FFFFF;
  // memory control register
  localparam int          MEMORY_CONTROL_REG_WAIT_HI  = 5;
  localparam int          MEMORY_CONTROL_REG_WAIT_LO  = 4;
  localparam logic [7:0]  MEMORY_CONTROL_REG_MASK     = 8'h30;
  localparam logic [7:0]  MEMORY_CONTROL_REG_RESET    = 8'h00;
  // register port offsets
  localparam logic [3:0]  REG_MEMORY_CONTROL_REG      = 4'h8;
  localparam logic [3:0]  REG_STATUS      = 4'h9;
  localparam logic [3:0]  REG_PCL         = 4'hA;
  localparam logic [3:0]  REG_PCH         = 4'hB;
  localparam logic [3:0]  REG_PCU         = 4'hC;
  localparam int          ST_BOOT_DONE    = 0;
  localparam int          ST_INT_ONLY     = 1;
  localparam int          ST_WIDE         = 2;
endpackage
`default_nettype wire

// ### verilog/pmd_cfg_store.sv
// configuration byte store, loaded at boot and write-once from software
`timescale 1ns/1ps
`default_nettype none
module pmd_cfg_store (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        load_en,
  input  wire logic [1:0]  load_word_idx,
  input  wire logic [15:0] load_word,
  input  wire logic        sw_wr,
  input  wire logic [2:0]  sw_idx,
  input  wire logic [7:0]  sw_wdata,
  output logic      [63:0] cfg_bytes
);
  typedef struct packed {
    logic [7:0][7:0] mem;
    logic [7:0]      lock;
  } pmd_cfg_t;

  pmd_cfg_t s_q;
  pmd_cfg_t s_d;
  logic [7:0] sel_byte;

  function automatic logic [7:0] pmd_impl_mask(input logic [2:0] idx);
    pmd_impl_mask = (idx == pmd_pkg::CFG3L_IDX) ? pmd_pkg::CFG3L_MASK : pmd_pkg::CFG_ERASED;
  endfunction

  always_comb begin
    s_d = s_q;
    if (sw_wr && !s_q.lock[sw_idx]) begin
      s_d.mem[sw_idx]  = sw_wdata & pmd_impl_mask(sw_idx);
      s_d.lock[sw_idx] = 1'b1;
    end
    if (load_en) begin
      s_d.mem[{load_word_idx, 1'b0}] = load_word[7:0] & pmd_impl_mask({load_word_idx, 1'b0});
      s_d.mem[{load_word_idx, 1'b1}] = load_word[15:8] & pmd_impl_mask({load_word_idx, 1'b1});
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.mem  <= pmd_pkg::CFG_RESET;
      s_q.lock <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_bytes = s_q.mem;
  assign sel_byte  = s_q.mem[sw_idx];

  a_write_once: assert property (@(posedge clk) disable iff (!rst_b)
    (sw_wr && s_q.lock[sw_idx] && !load_en) |=> (s_q.mem[$past(sw_idx)] == $past(sel_byte)))
    else $error("locked configuration byte changed on write");
  a_low_bits_zero: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.mem[pmd_pkg::CFG3L_IDX][2:0] == 3'h0)
    else $error("unimplemented configuration bits not zero");
endmodule
`default_nettype wire

// ### verilog/pmd_addr_decode.sv
// registered program address decoder: internal, external or zero fill
`timescale 1ns/1ps
`default_nettype none
module pmd_addr_decode (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [20:0] addr,
  input  wire logic [1:0]  mode,
  input  wire logic        shift_en,
  input  wire logic        has_ext,
  output logic             sel_int,
  output logic             sel_ext,
  output logic             sel_zero,
  output logic      [16:0] int_addr,
  output logic      [19:0] ext_addr
);
  typedef struct packed {
    logic        sel_int;
    logic        sel_ext;
    logic        sel_zero;
    logic [16:0] int_addr;
    logic [19:0] ext_addr;
  } pmd_dec_t;

  pmd_dec_t    s_q;
  pmd_dec_t    s_d;
  logic        on_chip;
  logic        ext_ok;
  logic [20:0] base;
  logic [20:0] masked;

  function automatic logic [20:0] pmd_width_mask(input logic [1:0] m);
    case (m)
      pmd_pkg::MODE_A12: pmd_width_mask = pmd_pkg::MASK_A12;
      pmd_pkg::MODE_A16: pmd_width_mask = pmd_pkg::MASK_A16;
      default:           pmd_width_mask = pmd_pkg::MASK_A20;
    endcase
  endfunction

  always_comb begin
    s_d     = s_q;
    on_chip = addr < pmd_pkg::FLASH_BYTES;
    ext_ok  = has_ext && (mode != pmd_pkg::MODE_INT);
    base    = shift_en ? (addr - pmd_pkg::FLASH_BYTES) : addr;
    masked  = base & pmd_width_mask(mode);
    // inside goes internal, above goes external, or zero fill in internal-only mode or without the bus
    s_d.sel_int  = on_chip;
    s_d.sel_ext  = !on_chip && ext_ok;
    s_d.sel_zero = !on_chip && !ext_ok;
    s_d.int_addr = addr[16:0];
    s_d.ext_addr = masked[19:0];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sel_int  = s_q.sel_int;
  assign sel_ext  = s_q.sel_ext;
  assign sel_zero = s_q.sel_zero;
  assign int_addr = s_q.int_addr;
  assign ext_addr = s_q.ext_addr;

  a_shift_base: assert property (@(posedge clk) disable iff (!rst_b)
    (shift_en && has_ext && mode == pmd_pkg::MODE_A20 && !on_chip)
      |=> (sel_ext && {1'b0, ext_addr} == (($past(addr) - pmd_pkg::FLASH_BYTES) & pmd_pkg::MASK_A20)))
    else $error("shifted external address wrong");
  a_zero_above: assert property (@(posedge clk) disable iff (!rst_b)
    (!on_chip && (mode == pmd_pkg::MODE_INT || !has_ext)) |=> (sel_zero && !sel_ext && !sel_int))
    else $error("address above flash not zero filled in internal mode");
endmodule
`default_nettype wire

// ### verilog/pmd_top.sv
// program memory map, boot configuration copy and fetch sequencer
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - 21-bit program counter, 2 Mbyte space
// - unimplemented program space returns zero
// - every reset loads vector 0000h
// - high interrupt 0008h, low interrupt 0018h
// - first three of the top four flash words copied at reset
// - config bytes ascending, word four reserved
// - config area is last eight bytes
// - internal-only mode reads zero above flash
// - 64-pin package is internal-only
// - extended mode splits internal and external
// - mode 11 internal-only, bus disabled
// - modes 10/01/00 give 12/16/20 address bits
// - shift bit remaps external base to zero
// - wait bit clear enables wait states
// - width bit selects 16 or 8 bits
// - config bits write-once, erased ones, low zero
// - program and data buses kept separate
// - shifted address is pc minus flash size
// - pc even, sequential step of two
module pmd_top (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        fetch_next,
  input  wire logic        branch_load,
  input  wire logic [20:0] branch_addr,
  input  wire logic        irq_hi,
  input  wire logic        irq_lo,
  output logic      [15:0] instr,
  output logic             instr_valid,
  output logic      [20:0] pc,
  output logic             boot_done,
  output logic             flash_rd,
  output logic      [16:0] flash_addr,
  input  wire logic [15:0] flash_rdata,
  output logic             ext_rd,
  output logic      [19:0] ext_addr,
  input  wire logic [15:0] ext_rdata,
  output logic             ext_bus_en,
  output logic             ext_wide
);
  typedef enum logic [3:0] {
    S_BOOT, S_BOOT_WAIT, S_BOOT_CAP, S_FETCH, S_ROUTE, S_INT_WAIT, S_INT_CAP, S_EXT_WAIT, S_HOLD
  } pmd_state_t;

  typedef struct packed {
    pmd_state_t  state;
    logic [1:0]  word_idx;
    logic [20:0] pc;
    logic        boot_done;
    logic [15:0] instr;
    logic        instr_valid;
    logic        flash_rd;
    logic [16:0] flash_addr;
    logic        ext_rd;
    logic [19:0] ext_addr;
    logic        ext_bus_en;
    logic        ext_wide;
    logic [2:0]  cnt;
    logic        beat;
    logic [7:0]  low_byte;
    logic [7:0]  memory_control_reg;
    logic [7:0]  rdata;
  } pmd_top_t;

  pmd_top_t    s_q;
  pmd_top_t    s_d;
  logic [63:0] cfg_bytes;
  logic [7:0]  cfg_low;
  logic [1:0]  mode;
  logic        int_only;
  logic [1:0]  wait_cnt;
  logic        load_en;
  logic        cfg_wr;
  logic        dec_int;
  logic        dec_ext;
  logic        dec_zero;
  logic [16:0] dec_int_addr;
  logic [19:0] dec_ext_addr;
  logic [20:0] cfg_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration decode

  assign cfg_low  = cfg_bytes[pmd_pkg::CFG3L_LSB +: 8];
  assign mode     = cfg_low[pmd_pkg::MODE_HI:pmd_pkg::MODE_LO];
  // no external bus in small package
  assign int_only = !pmd_pkg::HAS_EXT_BUS || (mode == pmd_pkg::MODE_INT);
  assign wait_cnt = cfg_low[pmd_pkg::WAIT_BIT] ? 2'h0 :
                    s_q.memory_control_reg[pmd_pkg::MEMORY_CONTROL_REG_WAIT_HI:pmd_pkg::MEMORY_CONTROL_REG_WAIT_LO];
  assign load_en  = (s_q.state == S_BOOT_CAP);
  assign cfg_wr   = reg_wr && !reg_addr[3];
  assign cfg_addr = pmd_pkg::CFG_BASE + (pmd_pkg::CFG_WORD_STEP * {19'h00000, s_q.word_idx});

  pmd_cfg_store u_cfg (
    .clk           (clk),
    .rst_b         (rst_b),
    .load_en       (load_en),
    .load_word_idx (s_q.word_idx),
    .load_word     (flash_rdata),
    .sw_wr         (cfg_wr),
    .sw_idx        (reg_addr[2:0]),
    .sw_wdata      (reg_wdata),
    .cfg_bytes     (cfg_bytes)
  );

  pmd_addr_decode u_dec (
    .clk      (clk),
    .rst_b    (rst_b),
    .addr     (s_q.pc),
    .mode     (mode),
    .shift_en (cfg_low[pmd_pkg::SHIFT_BIT]),
    .has_ext  (pmd_pkg::HAS_EXT_BUS),
    .sel_int  (dec_int),
    .sel_ext  (dec_ext),
    .sel_zero (dec_zero),
    .int_addr (dec_int_addr),
    .ext_addr (dec_ext_addr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer and register port

  always_comb begin
    s_d             = s_q;
    s_d.instr_valid = 1'b0;
    s_d.flash_rd    = 1'b0;
    s_d.ext_rd      = 1'b0;
    s_d.rdata       = 8'h00;
    s_d.ext_bus_en  = s_q.boot_done && !int_only;
    s_d.ext_wide    = !int_only && cfg_low[pmd_pkg::BW_BIT];
    case (s_q.state)
      S_BOOT: begin
        s_d.flash_rd   = 1'b1;
        s_d.flash_addr = cfg_addr[16:0];
        s_d.state      = S_BOOT_WAIT;
      end
      S_BOOT_WAIT: begin
        s_d.state = S_BOOT_CAP;
      end
      S_BOOT_CAP: begin
        if (s_q.word_idx == pmd_pkg::CFG_LAST_WORD) begin
          s_d.boot_done = 1'b1;
          s_d.pc        = pmd_pkg::RESET_VEC;
          s_d.state     = S_FETCH;
        end else begin
          s_d.word_idx = s_q.word_idx + 2'h1;
          s_d.state    = S_BOOT;
        end
      end
      S_FETCH: begin
        s_d.state = S_ROUTE;
      end
      // fetch shares the flash port with the boot copy
      S_ROUTE: begin
        if (dec_zero) begin
          s_d.instr       = 16'h0000;
          s_d.instr_valid = 1'b1;
          s_d.state       = S_HOLD;
        end else if (dec_int) begin
          s_d.flash_rd   = 1'b1;
          s_d.flash_addr = dec_int_addr;
          s_d.state      = S_INT_WAIT;
        end else begin
          s_d.ext_rd   = 1'b1;
          s_d.ext_addr = dec_ext_addr;
          s_d.cnt      = {1'b0, wait_cnt} + 3'h1;
          s_d.beat     = 1'b0;
          s_d.state    = S_EXT_WAIT;
        end
      end
      S_INT_WAIT: begin
        s_d.state = S_INT_CAP;
      end
      S_INT_CAP: begin
        s_d.instr       = flash_rdata;
        s_d.instr_valid = 1'b1;
        s_d.state       = S_HOLD;
      end
      // eight-bit bus takes two beats, low byte first
      S_EXT_WAIT: begin
        if (s_q.cnt != 3'h0) begin
          s_d.cnt = s_q.cnt - 3'h1;
        end else if (s_q.ext_wide) begin
          s_d.instr       = ext_rdata;
          s_d.instr_valid = 1'b1;
          s_d.state       = S_HOLD;
        end else if (!s_q.beat) begin
          s_d.low_byte = ext_rdata[7:0];
          s_d.beat     = 1'b1;
          s_d.ext_rd   = 1'b1;
          s_d.ext_addr = s_q.ext_addr + 20'h00001;
          s_d.cnt      = {1'b0, wait_cnt} + 3'h1;
        end else begin
          s_d.instr       = {ext_rdata[7:0], s_q.low_byte};
          s_d.instr_valid = 1'b1;
          s_d.state       = S_HOLD;
        end
      end
      S_HOLD: begin
        if (irq_hi) begin
          s_d.pc    = pmd_pkg::VEC_HI;
          s_d.state = S_FETCH;
        end else if (irq_lo) begin
          s_d.pc    = pmd_pkg::VEC_LO;
          s_d.state = S_FETCH;
        end else if (branch_load) begin
          s_d.pc    = {branch_addr[20:1], 1'b0};
          s_d.state = S_FETCH;
        end else if (fetch_next) begin
          s_d.pc    = s_q.pc + pmd_pkg::PC_STEP;
          s_d.state = S_FETCH;
        end
      end
      default: begin
        s_d.state = S_BOOT;
      end
    endcase
    if (reg_wr && reg_addr == pmd_pkg::REG_MEMORY_CONTROL_REG) begin
      s_d.memory_control_reg = reg_wdata & pmd_pkg::MEMORY_CONTROL_REG_MASK;
    end
    if (reg_rd) begin
      if (!reg_addr[3]) begin
        s_d.rdata = cfg_bytes[{reg_addr[2:0], 3'h0} +: 8];
      end else begin
        case (reg_addr)
          pmd_pkg::REG_MEMORY_CONTROL_REG: s_d.rdata = s_q.memory_control_reg;
          pmd_pkg::REG_STATUS: s_d.rdata = {5'h00, s_q.ext_wide, int_only, s_q.boot_done};
          pmd_pkg::REG_PCL:    s_d.rdata = s_q.pc[7:0];
          pmd_pkg::REG_PCH:    s_d.rdata = s_q.pc[15:8];
          pmd_pkg::REG_PCU:    s_d.rdata = {3'h0, s_q.pc[20:16]};
          default:             s_d.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q        <= '0;
      s_q.state  <= S_BOOT;
      s_q.pc     <= pmd_pkg::RESET_VEC;
      s_q.memory_control_reg <= pmd_pkg::MEMORY_CONTROL_REG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata   = s_q.rdata;
  assign instr       = s_q.instr;
  assign instr_valid = s_q.instr_valid;
  assign pc          = s_q.pc;
  assign boot_done   = s_q.boot_done;
  assign flash_rd    = s_q.flash_rd;
  assign flash_addr  = s_q.flash_addr;
  assign ext_rd      = s_q.ext_rd;
  assign ext_addr    = s_q.ext_addr;
  assign ext_bus_en  = s_q.ext_bus_en;
  assign ext_wide    = s_q.ext_wide;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_ext_issue_w16;
    s_q.state == S_ROUTE && dec_ext && cfg_low[pmd_pkg::BW_BIT] && wait_cnt == 2'h0;
  endsequence
  sequence s_ext_issue_w8;
    s_q.state == S_ROUTE && dec_ext && !cfg_low[pmd_pkg::BW_BIT] && wait_cnt == 2'h0;
  endsequence
  sequence s_ext_issue_wait3;
    s_q.state == S_ROUTE && dec_ext && cfg_low[pmd_pkg::BW_BIT] && wait_cnt == 2'h3;
  endsequence

  a_pc_even: assert property (s_q.pc[0] == 1'b0)
    else $error("program counter odd");
  a_seq_step: assert property ((s_q.state == S_HOLD && fetch_next && !irq_hi && !irq_lo && !branch_load)
    |=> (s_q.pc == $past(s_q.pc) + pmd_pkg::PC_STEP))
    else $error("sequential step not two");
  a_reset_vector: assert property ($rose(s_q.boot_done) |-> (s_q.pc == pmd_pkg::RESET_VEC))
    else $error("first fetch not at reset vector");
  a_no_early_fetch: assert property (!s_q.boot_done |-> (!s_q.ext_rd && !s_q.instr_valid))
    else $error("fetch before configuration copy");
  a_irq_hi_vec: assert property ((s_q.state == S_HOLD && irq_hi) |=> (s_q.pc == pmd_pkg::VEC_HI))
    else $error("high interrupt vector wrong");
  a_irq_lo_vec: assert property ((s_q.state == S_HOLD && !irq_hi && irq_lo) |=> (s_q.pc == 21'h000018))
    else $error("low interrupt vector wrong");
  a_boot_area: assert property ((s_q.state == S_BOOT && rst_b)
    |=> (s_q.flash_rd && {4'h0, s_q.flash_addr} >= 21'h01FFF8))
    else $error("boot read outside configuration area");
  a_zero_fill: assert property ((s_q.state == S_ROUTE && dec_zero) |=> (s_q.instr_valid && s_q.instr == 16'h0000))
    else $error("unimplemented space not zero");
  a_int_no_bus: assert property ((int_only && $past(int_only) && $past(int_only, 2)) |-> (!s_q.ext_rd && !s_q.ext_bus_en))
    else $error("external bus used in internal-only mode");
  a_ext_wide_read: assert property (s_ext_issue_w16 |=> s_q.ext_rd ##2 s_q.instr_valid)
    else $error("sixteen-bit external fetch timing wrong");
  a_ext_byte_read: assert property (s_ext_issue_w8 |=> s_q.ext_rd ##2 s_q.ext_rd ##2 s_q.instr_valid)
    else $error("eight-bit external fetch not two beats");
  a_ext_wait_three: assert property (s_ext_issue_wait3 |=> s_q.ext_rd ##1 !s_q.instr_valid [*4] ##1 s_q.instr_valid)
    else $error("three wait states not applied");
endmodule
`default_nettype wire

// ### verif/pmd_ext_mem.sv
// behavioural external program memory with wait states
`timescale 1ns/1ps
`default_nettype none
module pmd_ext_mem (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ext_rd,
  input  wire logic [19:0] ext_addr,
  input  wire logic [1:0]  wait_cycles,
  output logic      [15:0] ext_rdata
);
  logic [7:0]  addr_q;
  logic [1:0]  cnt_q;
  logic        busy_q;
  logic [15:0] junk_q;
  // data stand only in the sampled cycle; a toggling pattern hides stale words
  assign ext_rdata = (busy_q && cnt_q == 2'h0) ? {addr_q ^ 8'hC2, addr_q ^ 8'hC3} : junk_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 8'h00;
      cnt_q  <= 2'h0;
      busy_q <= 1'b0;
      junk_q <= 16'hA5A5;
    end else begin
      junk_q <= ~junk_q;
      if (ext_rd) begin
        addr_q <= ext_addr[7:0];
        cnt_q  <= wait_cycles;
        busy_q <= 1'b1;
      end else if (busy_q && cnt_q == 2'h0) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/pmd_top_bench.sv
// self-checking bench for the program memory decode block
`timescale 1ns/1ps
`default_nettype none
module pmd_top_bench;
  logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        fetch_next = 1'b0, branch_load = 1'b0, irq_hi = 1'b0, irq_lo = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, cfg3 = 8'hF8;
  logic [20:0] branch_addr = 21'h000000, pc;
  logic [15:0] instr, ext_rdata, flash_rdata = 16'h0000;
  logic        instr_valid, boot_done, flash_rd, ext_rd, ext_bus_en, ext_wide;
  logic [16:0] flash_addr;
  logic [19:0] ext_addr, ext_first = 20'h00000;
  logic [1:0]  wait_cycles = 2'h0;
  int          ext_beats = 0, failures = 0, samples_checked = 0;

  pmd_top DUT (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_next(fetch_next), .branch_load(branch_load),
    .branch_addr(branch_addr), .irq_hi(irq_hi), .irq_lo(irq_lo), .instr(instr),
    .instr_valid(instr_valid), .pc(pc), .boot_done(boot_done), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata), .ext_rd(ext_rd), .ext_addr(ext_addr),
    .ext_rdata(ext_rdata), .ext_bus_en(ext_bus_en), .ext_wide(ext_wide)
  );
  pmd_ext_mem ext_mem (
    .clk(clk), .rst_b(rst_b), .ext_rd(ext_rd), .ext_addr(ext_addr),
    .wait_cycles(wait_cycles), .ext_rdata(ext_rdata)
  );
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // flash image; config word three low byte follows cfg3
  function automatic logic [15:0] fimg(input logic [16:0] a);
    return (a == 17'h1FFFC) ? {8'h9C, cfg3} : {a[8:1] ^ 8'h3C, a[8:1]};
  endfunction
  // flash word stands one cycle, then its inverse so stale data never match
  always @(posedge clk) flash_rdata <= flash_rd ? fimg(flash_addr) : ~flash_rdata;
  always @(posedge clk) if (ext_rd === 1'b1) begin
    if (ext_beats == 0) ext_first = ext_addr;
    ext_beats++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wait_valid(output int n);
    for (n = 1; n <= 40; n++) begin
      @(posedge clk);
      #1;
      if (instr_valid === 1'b1) return;
    end
    failures++;
    $display("ERROR at %0t: no instruction", $time);
    conclude();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(32'(reg_rdata), 32'(e), "reg");
  endtask
  // k is {irq_hi, irq_lo, branch_load, fetch_next}; en of 0 skips the latency check
  task automatic fetch(input logic [3:0] k, input logic [20:0] a, input logic [20:0] ep,
                       input logic [15:0] ei, input int en, input int eb);
    int n;
    @(posedge clk);
    {irq_hi, irq_lo, branch_load, fetch_next} <= k;
    branch_addr <= a;
    ext_beats = 0;
    @(posedge clk);
    {irq_hi, irq_lo, branch_load, fetch_next} <= 4'h0;
    wait_valid(n);
    chk(32'(pc), 32'(ep), "pc");
    chk(32'(instr), 32'(ei), "instr");
    chk(32'(ext_beats), 32'(eb), "beats");
    if (en > 0) chk(32'(n + 1), 32'(en), "latency");
  endtask
  task automatic boot(input logic [7:0] c);
    int n;
    cfg3 = c;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(pc), 32'h0, "pc in reset");
    rst_b <= 1'b1;
    wait_valid(n);
    chk(32'(boot_done), 32'h1, "boot");
    chk(32'(pc), 32'h0, "vector");
    chk(32'(instr), 32'(fimg(17'h0)), "vector word");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic internal_only();
    boot(8'hF8);
    chk(32'(ext_bus_en), 32'h0, "bus enable");
    fetch(4'h2, 21'h000123, 21'h000122, fimg(17'h00122), 5, 0);
    fetch(4'h1, 21'h000000, 21'h000124, fimg(17'h00124), 5, 0);
    fetch(4'h2, 21'h01FFFE, 21'h01FFFE, fimg(17'h1FFFE), 5, 0);
    fetch(4'h1, 21'h000000, 21'h020000, 16'h0000, 3, 0);
    fetch(4'h2, 21'h1FFFFE, 21'h1FFFFE, 16'h0000, 3, 0);
    fetch(4'hA, 21'h000040, 21'h000008, fimg(17'h00008), 5, 0);
    fetch(4'h7, 21'h000040, 21'h000018, fimg(17'h00018), 5, 0);
  endtask
  task automatic registers();
    logic [63:0] cb;
    cb = {8'hFF, 8'hFF, 8'h9C, 8'hF8, 8'hC1, 8'hFD, 8'hC0, 8'hFC};
    boot(8'hF8);
    for (int i = 0; i < 8; i++) rd(4'(i), cb[i*8 +: 8]);
    rd(4'h9, 8'h03);
    wr(4'h4, 8'h3F);
    rd(4'h4, 8'h38);
    wr(4'h4, 8'hFF);
    rd(4'h4, 8'h38);
    rd(4'h9, 8'h03);
    wr(4'h8, 8'hFF);
    rd(4'h8, 8'h30);
    rd(4'hD, 8'h00);
  endtask
  task automatic extended();
    logic [31:0] cs;
    logic [7:0]  c;
    logic [1:0]  w;
    logic [20:0] a;
    logic [20:0] m;
    cs = {8'h88, 8'h40, 8'hD0, 8'hE8};
    a = 21'h134566;
    for (int i = 0; i < 4; i++) begin
      c = cs[i*8 +: 8];
      w = c[7] ? 2'h0 : 2'h3;
      m = (c[5:4] == 2'h2) ? pmd_pkg::MASK_A12 : (c[5:4] == 2'h1) ? pmd_pkg::MASK_A16 : pmd_pkg::MASK_A20;
      boot(c);
      wait_cycles = w;
      if (!c[7]) wr(4'h8, 8'h30);
      rd(4'h9, {5'h00, c[6], 2'h1});
      chk(32'(ext_bus_en), 32'h1, "bus enable");
      chk(32'(ext_wide), 32'(c[6]), "width");
      fetch(4'h2, 21'h000100, 21'h000100, fimg(17'h00100), 5, 0);
      fetch(4'h2, a, a, {a[7:0] ^ 8'hC2, a[7:0] ^ 8'hC3}, c[6] ? 5 + w : 0, c[6] ? 1 : 2);
      chk(32'(ext_first), 32'((c[3] ? a - pmd_pkg::FLASH_BYTES : a) & m), "ext addr");
      rd(4'hA, a[7:0]);
      rd(4'hB, a[15:8]);
      rd(4'hC, {3'h0, a[20:16]});
    end
  endtask
  initial begin
    internal_only();
    registers();
    extended();
    conclude();
  end
endmodule
`default_nettype wire
